// >>> verilog/dmpm_pkg.sv
// constants shared by the direct mode data pin mux
package dmpm_pkg;

    // ------------------------------------------------------------
    // data source select field
    // ------------------------------------------------------------
    localparam logic [1:0] DTMOD_GPIO = 2'h0;   // direct via general pin
    localparam logic [1:0] DTMOD_SDI  = 2'h1;   // direct via spi data-in
    localparam logic [1:0] DTMOD_FIFO = 2'h2;   // fifo path
    localparam logic [1:0] DTMOD_PN9  = 2'h3;   // internal pseudorandom

    // ------------------------------------------------------------
    // data clock select field
    // ------------------------------------------------------------
    localparam logic [1:0] TRCLK_NONE = 2'h0;   // no clock; with a pin source gfsk is forced to fsk
    localparam logic [1:0] TRCLK_GPIO = 2'h1;   // clock on general pin
    localparam logic [1:0] TRCLK_SDO  = 2'h2;   // clock on spi data-out
    localparam logic [1:0] TRCLK_IRQ  = 2'h3;   // clock on interrupt pin

    // ------------------------------------------------------------
    // modulation type field
    // ------------------------------------------------------------
    localparam logic [1:0] MOD_NONE = 2'h0;     // unmodulated carrier
    localparam logic [1:0] MOD_OOK  = 2'h1;     // on-off keying
    localparam logic [1:0] MOD_FSK  = 2'h2;     // frequency shift keying
    localparam logic [1:0] MOD_GFSK = 2'h3;     // gaussian filtered fsk

    // ------------------------------------------------------------
    // pseudorandom generator
    // ------------------------------------------------------------
    localparam logic [8:0] PN9_SEED = 9'h1ff;   // nonzero reset seed
    localparam int         PN9_TAP  = 4;        // x^5 term position

    // ------------------------------------------------------------
    // gain control and channel filter
    // ------------------------------------------------------------
    localparam logic [7:0]  AGC_HI_LEVEL  = 8'hc0;    // too strong above
    localparam logic [7:0]  AGC_LO_LEVEL  = 8'h40;    // too weak below
    localparam logic [3:0]  AGC_SETTLE    = 4'h8;     // last settle count; steps 10 cycles apart
    localparam logic [3:0]  PGA_STEP_MAX  = 4'h8;     // top pga step
    localparam logic [5:0]  PGA_STEP_DB   = 6'h03;    // db per pga step
    localparam logic [12:0] CHAN_BW_MIN   = 13'h001a; // 2.6 khz, 100 hz units
    localparam logic [12:0] CHAN_BW_MAX   = 13'h1838; // 620 khz, 100 hz units
    localparam logic [12:0] CHAN_BW_RESET = 13'h1838; // widest after reset

endpackage : dmpm_pkg

// >>> verilog/dmpm_pn_if.sv
// link between the mux and its pseudorandom bit source
`timescale 1ns/1ps
interface dmpm_pn_if;
    logic advance;   // one-cycle pulse: step the sequence
    logic bit_out;   // current sequence bit

    modport gen (input advance, output bit_out);
    modport use_side (output advance, input bit_out);
endinterface : dmpm_pn_if

// >>> verilog/dmpm_sync2.sv
// two flip-flop level synchroniser, no reset
`timescale 1ns/1ps
module dmpm_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d_async,
    output logic      [W-1:0] q_sync
);
    logic [W-1:0] meta_r;   // first stage, read only by second

    // ------------------------------------------------------------
    // two stage capture
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        meta_r <= d_async;
        q_sync <= meta_r;
    end
endmodule : dmpm_sync2

// >>> verilog/dmpm_pn9.sv
// nine stage pseudorandom bit generator
`timescale 1ns/1ps
module dmpm_pn9 (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    dmpm_pn_if.gen    pn
);
    logic [8:0] lfsr_r;   // shift register state
    logic       fb;       // feedback bit

    // x^9 + x^5 + 1
    assign fb = lfsr_r[8] ^ lfsr_r[dmpm_pkg::PN9_TAP];
    assign pn.bit_out = lfsr_r[8];

    // ------------------------------------------------------------
    // step once per bit period
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            lfsr_r <= dmpm_pkg::PN9_SEED;
        end else if (pn.advance) begin
            lfsr_r <= {lfsr_r[7:0], fb};
        end
    end
endmodule : dmpm_pn9

// >>> verilog/dmpm_top.sv
// direct mode data pin mux: pin routing, data clock, tx bit path, agc
//
// Contract
// - accept tx level at any rate, no clock
// - tx bits go to modulator unbuffered
// - async mode ignores bit rate setting
// - sample tx data at highest rate
// - async mode allows fsk and ook only; code only turns gfsk into fsk and passes unmodulated through
// - clock select 10 puts clock on data-out
// - data-out: spi when selected, else clock
// - select 11, no enables: clock on interrupt
// - source select 01 uses data-in pin
// - data-in stays spi input while selected
// - deselected data-in: tx input, rx output
// - unused data-out may carry interrupt
// - pseudorandom mode makes bits internally
// - agc switches lna between two gains
// - agc moves pga in 3 db steps
// - channel filter 620 khz down to 2.6
// - source select encoding 00 01 10 11
// - clock select encoding 00 01 10 11
`timescale 1ns/1ps
module dmpm_top (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        modem_clk,
    // pins
    input  wire logic        chip_select_n,
    input  wire logic        sdi_in,
    output logic             sdi_out,
    output logic             sdi_oe_n,
    output logic             sdo_out,
    output logic             sdo_oe_n,
    output logic             interrupt_out_n,
    input  wire logic        gpio_in,
    output logic             gpio_data_out,
    output logic             gpio_clk_out,
    // configuration
    input  wire logic [1:0]  dtmod,
    input  wire logic [1:0]  trclk,
    input  wire logic [1:0]  modtyp,
    input  wire logic        invert_tx,
    input  wire logic [15:0] rate_half,
    input  wire logic [7:0]  irq_enable1,
    input  wire logic [7:0]  irq_enable2,
    input  wire logic        irq_on_sdo,
    input  wire logic        tx_on,
    input  wire logic        rx_on,
    // device core side
    input  wire logic        spi_sdo_data,
    input  wire logic        irq_core_n,
    input  wire logic        fifo_tx_bit,
    output logic             rx_bit_to_core,
    output logic             async_mode,
    output logic [1:0]       mod_type,
    // modem domain
    output logic             mod_tx_bit,
    input  wire logic        rx_demod_bit,
    // gain control and filter
    input  wire logic [7:0]  rssi_level,
    output logic             lna_gain_hi,
    output logic [3:0]       pga_step,
    output logic [5:0]       pga_gain_db,
    input  wire logic [12:0] chan_bw_req,
    output logic [12:0]      chan_bw
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [2:0]  pin_s;        // synced cs, data-in, gpio
    logic        cs_high;      // chip deselected
    logic        sdi_s;        // synced data-in level
    logic        gpio_s;       // synced gpio level
    logic        rx_s;         // demod bit in system domain
    logic [1:0]  mdm_s;        // reset and tx bit in modem domain
    logic [15:0] div_cnt_r;    // data clock divider count
    logic        dclk_r;       // data clock level
    logic        bit_tick;     // rising data clock edge
    logic        radio_on;     // receive or transmit active
    logic        async_nxt;    // async direct transmit selected
    logic        tx_bit_r;     // chosen tx bit, system domain
    logic        mod_tx_nxt;   // modem side next tx bit
    logic        irq_none;     // every interrupt enable clear
    logic [3:0]  settle_r;     // agc wait counter

    dmpm_pn_if pn_link ();     // pseudorandom bit link

    // ------------------------------------------------------------
    // agc states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        AGC_OFF,
        AGC_SETTLE,
        AGC_ADJUST
    } dmpm_agc_t;

    dmpm_agc_t agc_r;          // agc state

    // ------------------------------------------------------------
    // pin and modem crossings
    // ------------------------------------------------------------
    // async pins pass two flops before use
    dmpm_sync2 #(.W(3)) u_pin_sync (
        .clk     (sys_clk),
        .d_async ({chip_select_n, sdi_in, gpio_in}),
        .q_sync  (pin_s)
    );

    // demod bit crosses into system domain
    dmpm_sync2 #(.W(1)) u_rx_sys (
        .clk     (sys_clk),
        .d_async (rx_demod_bit),
        .q_sync  (rx_s)
    );

    // reset and tx bit cross into modem domain
    dmpm_sync2 #(.W(2)) u_mdm_sync (
        .clk     (modem_clk),
        .d_async ({reset_n, tx_bit_r}),
        .q_sync  (mdm_s)
    );

    assign cs_high = pin_s[2];
    assign sdi_s   = pin_s[1];
    assign gpio_s  = pin_s[0];

    // ------------------------------------------------------------
    // pseudorandom source
    // ------------------------------------------------------------
    dmpm_pn9 u_pn9 (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .pn      (pn_link.gen)
    );

    assign pn_link.advance = bit_tick && (dtmod == dmpm_pkg::DTMOD_PN9);

    // ------------------------------------------------------------
    // decoding used by several processes
    // ------------------------------------------------------------
    // direct modes that take data from a pin
    function automatic logic is_direct(input logic [1:0] sel);
        is_direct = (sel == dmpm_pkg::DTMOD_GPIO) || (sel == dmpm_pkg::DTMOD_SDI);
    endfunction : is_direct

    // pick the tx bit for the selected source
    function automatic logic pick_src(input logic [1:0] sel, input logic gpio_b,
        input logic sdi_b, input logic fifo_b, input logic pn_b, input logic cs_hi);
        case (sel)
            dmpm_pkg::DTMOD_GPIO: pick_src = gpio_b;
            dmpm_pkg::DTMOD_SDI:  pick_src = sdi_b && cs_hi;
            dmpm_pkg::DTMOD_FIFO: pick_src = fifo_b;
            dmpm_pkg::DTMOD_PN9:  pick_src = pn_b;
            default:              pick_src = 1'b0;
        endcase
    endfunction : pick_src

    assign radio_on  = tx_on || rx_on;
    assign irq_none  = (irq_enable1 == 8'h00) && (irq_enable2 == 8'h00);
    // async when a pin feeds data and no clock is offered
    assign async_nxt = is_direct(dtmod) && (trclk == dmpm_pkg::TRCLK_NONE);
    assign bit_tick  = radio_on && (div_cnt_r == rate_half) && !dclk_r;

    // ------------------------------------------------------------
    // data clock divider
    // ------------------------------------------------------------
    // square wave at the programmed rate, idle low outside radio
    always_ff @(posedge sys_clk) begin
        if (!reset_n || !radio_on) begin
            div_cnt_r <= 16'h0000;
            dclk_r    <= 1'b0;
        end else if (div_cnt_r == rate_half) begin
            div_cnt_r <= 16'h0000;
            dclk_r    <= !dclk_r;
        end else begin
            div_cnt_r <= div_cnt_r + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // tx bit selection, system domain
    // ------------------------------------------------------------
    // pin levels taken every cycle, no rate needed
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            tx_bit_r <= 1'b0;
        end else begin
            // straight through, no buffering; zero while not sending
            tx_bit_r <= tx_on && (pick_src(dtmod, gpio_s, sdi_s, fifo_tx_bit,
                                  pn_link.bit_out, cs_high) ^ invert_tx);
        end
    end

    // ------------------------------------------------------------
    // tx bit to modulator, modem domain
    // ------------------------------------------------------------
    // every rising modem edge samples, the top oversampling rate
    assign mod_tx_nxt = mdm_s[1] ? mdm_s[0] : 1'b0;

    always_ff @(posedge modem_clk) begin
        mod_tx_bit <= mod_tx_nxt;
    end

    // ------------------------------------------------------------
    // mode status and modulation type
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            async_mode <= 1'b0;
            mod_type   <= dmpm_pkg::MOD_NONE;
        end else begin
            async_mode <= async_nxt;
            // no gaussian filter without a known rate
            if (async_nxt && (modtyp == dmpm_pkg::MOD_GFSK)) begin
                mod_type <= dmpm_pkg::MOD_FSK;
            end else begin
                mod_type <= modtyp;
            end
        end
    end

    // ------------------------------------------------------------
    // spi data-in pin
    // ------------------------------------------------------------
    // drives demod bits only when deselected in receive
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sdi_out  <= 1'b0;
            sdi_oe_n <= 1'b1;
        end else if (cs_high && (dtmod == dmpm_pkg::DTMOD_SDI) && rx_on) begin
            sdi_out  <= rx_s;
            sdi_oe_n <= 1'b0;
        end else begin
            // spi input or tx input: released
            sdi_out  <= 1'b0;
            sdi_oe_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // spi data-out pin
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sdo_out  <= 1'b0;
            sdo_oe_n <= 1'b1;
        end else if (!cs_high) begin
            // selected: ordinary serial output
            sdo_out  <= spi_sdo_data;
            sdo_oe_n <= 1'b0;
        end else if ((trclk == dmpm_pkg::TRCLK_SDO) && radio_on) begin
            sdo_out  <= dclk_r;
            sdo_oe_n <= 1'b0;
        end else if ((trclk != dmpm_pkg::TRCLK_SDO) && irq_on_sdo) begin
            sdo_out  <= irq_core_n;
            sdo_oe_n <= 1'b0;
        end else begin
            // idle: released
            sdo_out  <= 1'b0;
            sdo_oe_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // interrupt pin
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            interrupt_out_n <= 1'b1;
        end else if ((trclk == dmpm_pkg::TRCLK_IRQ) && irq_none) begin
            interrupt_out_n <= dclk_r;
        end else begin
            interrupt_out_n <= irq_core_n;
        end
    end

    // ------------------------------------------------------------
    // general pin outputs and rx bit to core
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            gpio_data_out  <= 1'b0;
            gpio_clk_out   <= 1'b0;
            rx_bit_to_core <= 1'b0;
        end else begin
            gpio_data_out  <= (dtmod == dmpm_pkg::DTMOD_GPIO) && rx_on && rx_s;
            gpio_clk_out   <= (trclk == dmpm_pkg::TRCLK_GPIO) && dclk_r;
            rx_bit_to_core <= rx_on && rx_s;
        end
    end

    // ------------------------------------------------------------
    // gain control loop
    // ------------------------------------------------------------
    // one step at a time, then a settle wait
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            agc_r       <= AGC_OFF;
            settle_r    <= 4'h0;
            lna_gain_hi <= 1'b1;
            pga_step    <= dmpm_pkg::PGA_STEP_MAX;
        end else begin
            case (agc_r)
                AGC_OFF: begin
                    settle_r <= 4'h0;
                    if (rx_on) begin
                        agc_r <= AGC_SETTLE;
                    end
                end
                AGC_SETTLE: begin
                    if (!rx_on) begin
                        agc_r <= AGC_OFF;
                    end else if (settle_r == dmpm_pkg::AGC_SETTLE) begin
                        settle_r <= 4'h0;
                        agc_r    <= AGC_ADJUST;
                    end else begin
                        settle_r <= settle_r + 4'h1;
                    end
                end
                AGC_ADJUST: begin
                    agc_r <= AGC_SETTLE;
                    if (rssi_level > dmpm_pkg::AGC_HI_LEVEL) begin
                        // too strong: pga first, then lna
                        if (pga_step != 4'h0) begin
                            pga_step <= pga_step - 4'h1;
                        end else begin
                            lna_gain_hi <= 1'b0;
                        end
                    end else if (rssi_level < dmpm_pkg::AGC_LO_LEVEL) begin
                        // too weak: lna first, then pga
                        if (!lna_gain_hi) begin
                            lna_gain_hi <= 1'b1;
                        end else if (pga_step != dmpm_pkg::PGA_STEP_MAX) begin
                            pga_step <= pga_step + 4'h1;
                        end
                    end
                end
                default: agc_r <= AGC_OFF;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pga gain in db and channel filter bandwidth
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pga_gain_db <= 6'h00;
            chan_bw     <= dmpm_pkg::CHAN_BW_RESET;
        end else begin
            pga_gain_db <= 6'(pga_step * dmpm_pkg::PGA_STEP_DB);
            if (chan_bw_req < dmpm_pkg::CHAN_BW_MIN) begin
                chan_bw <= dmpm_pkg::CHAN_BW_MIN;
            end else if (chan_bw_req > dmpm_pkg::CHAN_BW_MAX) begin
                chan_bw <= dmpm_pkg::CHAN_BW_MAX;
            end else begin
                chan_bw <= chan_bw_req;
            end
        end
    end

endmodule : dmpm_top

// >>> test/dmpm_host_mcu.sv
// host microcontroller model on the select and data-in pins
`timescale 1ns/1ps
module dmpm_host_mcu (
    input  wire logic sys_clk,
    input  wire logic cs_n_cmd,   // wanted select level
    input  wire logic drv_cmd,    // host drives data-in
    input  wire logic bit_cmd,    // host data level
    input  wire logic sdi_out,    // device drive value
    input  wire logic sdi_oe_n,   // device drives when low
    output logic      chip_select_n,
    output logic      sdi_in
);
    logic cs_r  = 1'b1;   // select pin
    logic bit_r = 1'b0;   // host data bit
    // host paces its own bits, no clock taken from the device
    always @(posedge sys_clk) begin
        cs_r  <= cs_n_cmd;
        bit_r <= bit_cmd;
    end
    assign chip_select_n = cs_r;
    // device, else host, else inverse while floating
    assign sdi_in = !sdi_oe_n ? sdi_out : (drv_cmd ? bit_r : ~bit_r);
endmodule : dmpm_host_mcu

// >>> test/dmpm_top_sva.sv
// assertion checker for the direct mode data pin mux
`timescale 1ns/1ps
module dmpm_top_sva (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        chip_select_n,
    input wire logic        sdi_oe_n,
    input wire logic        sdo_out,
    input wire logic        sdo_oe_n,
    input wire logic        interrupt_out_n,
    input wire logic [1:0]  dtmod,
    input wire logic [1:0]  trclk,
    input wire logic [1:0]  modtyp,
    input wire logic        irq_on_sdo,
    input wire logic        spi_sdo_data,
    input wire logic        irq_core_n,
    input wire logic        async_mode,
    input wire logic [1:0]  mod_type,
    input wire logic [3:0]  pga_step,
    input wire logic [12:0] chan_bw_req,
    input wire logic [12:0] chan_bw
);
    // ----------
    // helper logic
    // ----------
    logic [2:0] lo_r;    // samples with chip selected
    logic [2:0] hi_r;    // samples with chip deselected
    logic       asy_c;   // direct pin source, no clock
    assign asy_c = (dtmod == dmpm_pkg::DTMOD_GPIO || dtmod == dmpm_pkg::DTMOD_SDI)
                   && trclk == dmpm_pkg::TRCLK_NONE;
    // saturating run counters, past sync latency
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            lo_r <= 3'h0;
            hi_r <= 3'h0;
        end else begin
            lo_r <= chip_select_n ? 3'h0 : lo_r + {2'h0, lo_r != 3'h7};
            hi_r <= !chip_select_n ? 3'h0 : hi_r + {2'h0, hi_r != 3'h7};
        end
    end
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // ----------
    // assertions
    // ----------
    a_async_flag: assert property ($past(reset_n) |-> async_mode == $past(asy_c))
        else $error("async flag wrong");
    a_no_gfsk: assert property ($past(reset_n) |-> mod_type == (($past(asy_c) &&
        $past(modtyp) == dmpm_pkg::MOD_GFSK) ? dmpm_pkg::MOD_FSK : $past(modtyp)))
        else $error("modulation type wrong");
    a_pga_step_one: assert property (pga_step != $past(pga_step)
        |-> pga_step <= 4'h8 && (pga_step - $past(pga_step) == 4'h1
        || $past(pga_step) - pga_step == 4'h1)) else $error("pga jump");
    a_bw_clamp: assert property ($past(reset_n) |-> chan_bw ==
        (($past(chan_bw_req) < dmpm_pkg::CHAN_BW_MIN) ? dmpm_pkg::CHAN_BW_MIN :
        ($past(chan_bw_req) > dmpm_pkg::CHAN_BW_MAX) ? dmpm_pkg::CHAN_BW_MAX :
        $past(chan_bw_req))) else $error("bandwidth not clamped");
    a_sdo_spi_out: assert property (lo_r > 3'h4 |-> !sdo_oe_n
        && sdo_out == $past(spi_sdo_data)) else $error("data-out not serial");
    a_sdi_in_sel: assert property (lo_r > 3'h4 |-> sdi_oe_n)
        else $error("data-in driven while selected");
    a_sdo_irq_alt: assert property (hi_r > 3'h4 && $past(irq_on_sdo) &&
        $past(trclk) != dmpm_pkg::TRCLK_SDO |-> !sdo_oe_n && sdo_out == $past(irq_core_n))
        else $error("data-out not interrupt");
    a_irq_pin_plain: assert property ($past(reset_n) &&
        $past(trclk) != dmpm_pkg::TRCLK_IRQ |-> interrupt_out_n == $past(irq_core_n))
        else $error("interrupt pin wrong");
    c_async: cover property (async_mode);
    c_pga_min: cover property (pga_step == 4'h0);
    c_sdo_alt: cover property (hi_r == 3'h7 && !sdo_oe_n);
endmodule : dmpm_top_sva
bind dmpm_top dmpm_top_sva u_sva (.*);

// >>> test/dmpm_top_test.sv
// self-checking bench for the direct mode data pin mux
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR %0t: got %h want %h", $time, a, b); end end
`define WAITC(c, n) for (w = 0; w < n && !(c); w++) @(posedge sys_clk);
module dmpm_top_test;
    // ----------
    // stimulus and observed pins
    // ----------
    logic        sys_clk = 1'b0, modem_clk = 1'b0, reset_n = 1'b0;
    logic        cs_cmd = 1'b1, drv_cmd = 1'b1, bit_cmd = 1'b0;   // host requests
    logic        tx_on = 1'b0, rx_on = 1'b0, irq_on_sdo = 1'b0, rx_demod_bit = 1'b0;
    logic        spi_sdo_data = 1'b0, irq_core_n = 1'b1;
    logic        chip_select_n, sdi_in, sdi_out, sdi_oe_n, sdo_out, sdo_oe_n;
    logic        interrupt_out_n, gpio_data_out, gpio_clk_out, rx_bit_to_core;
    logic        async_mode, mod_tx_bit, lna_gain_hi;
    logic [1:0]  dtmod = 2'h2, trclk = 2'h0, modtyp = 2'h2, mod_type;
    logic [15:0] rate_half = 16'h001f;   // toggle every 32
    logic [7:0]  irq_enable1 = 8'h01, irq_enable2 = 8'h00, rssi_level = 8'h80;
    logic [3:0]  pga_step;
    logic [5:0]  pga_gain_db;
    logic [12:0] chan_bw_req = 13'h0123, chan_bw;
    logic [12:0] bw_req [3] = '{13'h0000, 13'h1fff, 13'h0123};
    logic [8:0]  pn_r = dmpm_pkg::PN9_SEED;   // reference sequence
    int          mismatches = 0, n_tests = 0, w, t0, cyc = 0;

    always #4 sys_clk = ~sys_clk;
    initial #7 forever #15 modem_clk = ~modem_clk;   // unrelated phase
    always @(posedge sys_clk) cyc <= cyc + 1;

    dmpm_top u_dut (.gpio_in(1'b0), .invert_tx(1'b0), .fifo_tx_bit(1'b0), .*);
    dmpm_host_mcu u_host (.cs_n_cmd(cs_cmd), .*);

    // counts, verdict, end of run
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    // set source, clock and radio, let pins settle
    task automatic cfg(input logic [1:0] dm, input logic [1:0] tc, input logic t, input logic r);
        @(posedge sys_clk);
        dtmod <= dm;
        trclk <= tc;
        tx_on <= t;
        rx_on <= r;
        repeat (6) @(posedge sys_clk);
    endtask : cfg

    initial begin
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        `CHK({chan_bw, pga_step}, {dmpm_pkg::CHAN_BW_RESET, 4'h8})
        // pseudorandom bits, clock on data-out
        cfg(dmpm_pkg::DTMOD_PN9, dmpm_pkg::TRCLK_SDO, 1'b1, 1'b0);
        for (int k = 0; k < 12; k++) begin
            `WAITC(sdo_out === 1'b1, 200)
            if (k == 1)
                `CHK(cyc - t0, 64)
            t0 = cyc;
            pn_r = {pn_r[7:0], pn_r[8] ^ pn_r[4]};
            `WAITC(sdo_out === 1'b0, 200)
            `CHK(mod_tx_bit, pn_r[8])
        end
        // data clock on the interrupt pin
        irq_enable1 <= 8'h00;
        cfg(dmpm_pkg::DTMOD_PN9, dmpm_pkg::TRCLK_IRQ, 1'b1, 1'b0);
        for (int k = 0; k < 2; k++) begin
            t0 = cyc;
            `WAITC(interrupt_out_n === 1'b0, 200)
            `WAITC(interrupt_out_n === 1'b1, 200)
        end
        `CHK(cyc - t0, 64)
        // async transmit on data-in, rate unset
        rate_half <= 16'hffff;
        cfg(dmpm_pkg::DTMOD_SDI, dmpm_pkg::TRCLK_NONE, 1'b1, 1'b0);
        `CHK(async_mode, 1'b1)
        for (int k = 0; k < 6; k++) begin
            bit_cmd <= ~bit_cmd;
            @(posedge sys_clk);
            `WAITC(mod_tx_bit === bit_cmd, 40)
            `CHK(mod_tx_bit, bit_cmd)
            repeat (3 * k) @(posedge sys_clk);
        end
        // receive: data-in carries demodulated bits
        drv_cmd <= 1'b0;
        cfg(dmpm_pkg::DTMOD_SDI, dmpm_pkg::TRCLK_NONE, 1'b0, 1'b1);
        for (int k = 0; k < 3; k++) begin
            @(posedge modem_clk);
            rx_demod_bit <= ~rx_demod_bit;
            @(posedge sys_clk);
            `WAITC(sdi_out === rx_demod_bit && rx_bit_to_core === rx_demod_bit, 40)
            `CHK({sdi_oe_n, sdi_out, rx_bit_to_core}, {1'b0, {2{rx_demod_bit}}})
            `CHK({gpio_data_out, gpio_clk_out}, 2'h0)
        end
        // data-out as interrupt, then as serial output
        irq_on_sdo <= 1'b1;
        cfg(dmpm_pkg::DTMOD_FIFO, dmpm_pkg::TRCLK_NONE, 1'b0, 1'b0);
        `CHK({sdo_oe_n, sdo_out}, 2'h1)
        irq_core_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK({sdo_oe_n, sdo_out}, 2'h0)
        cs_cmd <= 1'b0;
        spi_sdo_data <= 1'b1;
        repeat (6) @(posedge sys_clk);
        `CHK({sdo_oe_n, sdo_out, sdi_oe_n}, 3'h3)
        // every source, clock and modulation code
        for (int d = 0; d < 4; d++)
            for (int c = 0; c < 4; c++)
                for (int m = 0; m < 4; m++) begin
                    dtmod <= 2'(d);
                    trclk <= 2'(c);
                    modtyp <= 2'(m);
                    repeat (2) @(posedge sys_clk);
                    `CHK(async_mode, d < 2 && c == 0)
                    `CHK(mod_type, (d < 2 && c == 0 && m == 3) ? 2'h2 : 2'(m))
                end
        // gain loop, strong then weak signal
        rx_on <= 1'b1;
        rssi_level <= 8'hff;
        `WAITC(pga_step === 4'h0 && lna_gain_hi === 1'b0, 300)
        repeat (2) @(posedge sys_clk);
        `CHK({lna_gain_hi, pga_step, pga_gain_db}, 11'h000)
        rssi_level <= 8'h00;
        `WAITC(pga_step === 4'h8 && lna_gain_hi === 1'b1, 300)
        repeat (2) @(posedge sys_clk);
        `CHK({lna_gain_hi, pga_step, pga_gain_db}, {1'b1, 4'h8, 6'h18})
        // channel filter limits
        foreach (bw_req[i]) begin
            chan_bw_req <= bw_req[i];
            repeat (2) @(posedge sys_clk);
            `CHK(chan_bw, i == 0 ? dmpm_pkg::CHAN_BW_MIN :
                 i == 1 ? dmpm_pkg::CHAN_BW_MAX : bw_req[i])
        end
        end_sim();
    end

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        end_sim();
    end
endmodule : dmpm_top_test
